// ===== rtl/srk_pkg.sv
// Purpose: shared constants for the static ram controller
// Assumes: mclk at 100 MHz
// Notes:   times in ns, counts derived as whole cycles
package srk_pkg;
   localparam int CLK_PERIOD_NS            = 10;
   localparam int ADDR_W                   = 10;
   localparam int DEPTH                    = 1024;
   localparam int READ_CYCLE_MIN_NS        = 450;
   localparam int ACCESS_MAX_NS            = 450;
   localparam int SELECT_ACCESS_MAX_NS     = 230;
   localparam int WRITE_CYCLE_MIN_NS       = 450;
   localparam int ADDRESS_BEFORE_STROBE_NS = 20;
   localparam int WRITE_STROBE_WIDTH_NS    = 300;
   localparam int SELECT_BEFORE_WRITE_END_NS      = 300;
   localparam int INPUT_SETUP_BEFORE_WRITE_END_NS = 300;
   // least times round up
   localparam int READ_CYCLE_MIN_CYC   = (READ_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACCESS_CYC           = (ACCESS_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_CYCLE_MIN_CYC  = (WRITE_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADDRESS_BEFORE_STROBE_CYC =
      (ADDRESS_BEFORE_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_STROBE_WIDTH_CYC =
      (WRITE_STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
endpackage

// ===== rtl/srk_sync.sv
// Purpose: three-flop synchroniser for the memory data output pin
// Assumes: one clock, asynchronous active-low reset
// Notes:   value changes once the second and third stages agree
`timescale 1ns/1ns
module srk_sync (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic pin,
   output logic      level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } srk_sync_s;
   srk_sync_s st;
   srk_sync_s next_st;
   // shift chain; first stage feeds only the second
   always_comb begin
      next_st     = st;
      next_st.s1  = pin;
      next_st.s2  = st.s1;
      next_st.s3  = st.s2;
      if (st.s2 == st.s3) begin
         next_st.lvl = st.s3;
      end
   end
   // register state
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign level = st.lvl;
endmodule

// ===== rtl/srk_ctrl.sv
// Purpose: controller driving a 1024x1 static ram through its pins
//          one request in, one answer out, single bits only
// Assumes: mclk 100 MHz; ram is asynchronous; one request at a time
//          ram data pin reaches this block as a resolved level
//          requester holds its request until it is taken
// Notes:   read data is sampled at the end of the read cycle, after sync delay
//          read: address and select go out together, the full access time
//          passes, the pin crosses the synchroniser, then the settled
//          level is latched and answered
//          write: address, data and select go out together, the strobe
//          falls once the address has settled, stays low for its full
//          width, and the cycle is padded to the least write length
//          select rises one cycle after the answer, so the ram output
//          floats before the next request can be taken
//          answer: rsp_valid lasts one cycle; rsp_rdata stands until the
//          next read is answered, writes leave it alone
//          ready: high only while idle, low from take until select rises
//          counts round up, so each phase lasts at least its least time;
//          an 8-bit counter covers every phase at 100 MHz, a faster
//          clock needs a wider one
//          the ram output is never sampled while the strobe is low
//          hazard: the read sample edge comes only after the pin has
//          crossed every synchroniser stage; a shorter count reads stale data
//          a request that arrives while busy waits; nothing is queued
//          limitation: one ram only; a second ram needs its own select
`timescale 1ns/1ns
module srk_ctrl
   import srk_pkg::*;
#(
   parameter int SYNC_CYC = 3
) (
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic              req_wdata,
   output logic                   rsp_valid,
   output logic                   rsp_rdata,
   output logic [ADDR_W-1:0]      ram_addr,
   output logic                   ram_din,
   output logic                   ram_select_n,
   output logic                   ram_write_n,
   input  wire logic              ram_dout
);

   // sequencer phases
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RD,
      ST_WR_SETUP,
      ST_WR_STROBE,
      ST_WR_TAIL,
      ST_DONE
   } srk_state_e;

   // every register of the block but the synchroniser in one word
   typedef struct packed {
      srk_state_e        state;
      logic [CNT_W-1:0]  cnt;
      logic [ADDR_W-1:0] addr;
      logic              din;
      logic              sel_n;
      logic              wr_n;
      logic              rsp;
      logic              rdata;
   } srk_ctrl_s;

   // phase lengths in whole cycles
   // read: access time, then the sync chain, then one edge to catch the
   // settled pin and one more for the agreement stage
   localparam int               RD_SLACK = 2;
   localparam logic [CNT_W-1:0] RD_CNT  = CNT_W'(ACCESS_CYC + SYNC_CYC + RD_SLACK);
   // write: address settles before the strobe falls
   localparam logic [CNT_W-1:0] SU_CNT  = CNT_W'(ADDRESS_BEFORE_STROBE_CYC);
   // write: strobe low for its whole width
   localparam logic [CNT_W-1:0] WP_CNT  = CNT_W'(WRITE_STROBE_WIDTH_CYC);
   // write: rest of the least write cycle after setup and strobe
   localparam logic [CNT_W-1:0] TL_CNT  =
      CNT_W'(WRITE_CYCLE_MIN_CYC - ADDRESS_BEFORE_STROBE_CYC - WRITE_STROBE_WIDTH_CYC);

   // state word and its next value
   srk_ctrl_s st;
   srk_ctrl_s next_st;
   logic      dout_sync;

   // counter is on the last cycle of a phase
   function automatic logic cnt_last(input logic [CNT_W-1:0] cnt);
      return (cnt == CNT_W'(1));
   endfunction

   // dout comes from an asynchronous pin
   srk_sync u_sync (
      .mclk  (mclk),
      .rstn  (rstn),
      .pin   (ram_dout),
      .level (dout_sync)
   );

   // sequencer for read and write cycles
   always_comb begin
      next_st     = st;
      next_st.rsp = 1'b0;
      // counter runs down by itself; phases reload it
      if (st.cnt != CNT_ZERO) begin
         next_st.cnt = st.cnt - 8'h01;
      end
      // one branch per phase
      unique case (st.state)
         // wait for a request; ram deselected, strobe high
         ST_IDLE: begin
            next_st.sel_n = 1'b1;   // deselected lets ram output float
            next_st.wr_n  = 1'b1;
            if (req_valid) begin
               // take it: address, data and select go out together
               next_st.addr  = req_addr;   // ten-bit decode in ram
               next_st.din   = req_wdata;
               next_st.sel_n = 1'b0;       // select only this ram
               // a write starts with address setup, a read with the access wait
               if (req_write) begin
                  next_st.state = ST_WR_SETUP;
                  next_st.cnt   = SU_CNT;  // address before strobe
               end else begin
                  next_st.state = ST_RD;
                  next_st.cnt   = RD_CNT;  // full read cycle plus sync
               end
            end
         end

         // read: wait access time plus sync, select held low
         ST_RD: begin
            // address and select held steady the whole cycle
            if (cnt_last(st.cnt)) begin
               // last count: latch the settled level and answer
               next_st.rdata = dout_sync;  // read returns stored bit
               next_st.rsp   = 1'b1;
               next_st.state = ST_DONE;
            end
         end

         // address settles before the strobe falls
         ST_WR_SETUP: begin
            if (cnt_last(st.cnt)) begin
               // last count: strobe falls
               next_st.wr_n  = 1'b0;
               next_st.cnt   = WP_CNT;     // strobe width
               next_st.state = ST_WR_STROBE;
            end
         end

         // strobe low for its whole width
         ST_WR_STROBE: begin
            // select and data stable across the strobe
            if (cnt_last(st.cnt)) begin
               // last count: strobe rises and the bit is stored
               next_st.wr_n  = 1'b1;       // bit stored at strobe end
               next_st.cnt   = TL_CNT;     // pad to full write cycle
               next_st.state = ST_WR_TAIL;
            end
         end

         // pad to the least write length
         ST_WR_TAIL: begin
            // output not sampled during write
            if (st.cnt <= 8'h01) begin
               // least write length reached: answer
               next_st.rsp   = 1'b1;
               next_st.state = ST_DONE;
            end
         end

         // let select rise for one cycle before the next take
         ST_DONE: begin
            next_st.sel_n = 1'b1;
            next_st.state = ST_IDLE;
         end

         // unused state codes fall back to a deselected idle
         default: begin
            next_st.sel_n = 1'b1;
            next_st.wr_n  = 1'b1;
            next_st.state = ST_IDLE;
         end
      endcase
   end

   // register state; no refresh ever needed
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         // reset leaves the ram deselected and the strobe high
         st       <= '0;
         st.state <= ST_IDLE;
         st.sel_n <= 1'b1;
         st.wr_n  <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // handshake output straight from the state
   assign req_ready    = (st.state == ST_IDLE);

   // answer and ram pins straight from flops
   assign rsp_valid    = st.rsp;
   assign rsp_rdata    = st.rdata;
   assign ram_addr     = st.addr;
   assign ram_din      = st.din;
   assign ram_select_n = st.sel_n;
   assign ram_write_n  = st.wr_n;
endmodule

// ===== sim/srk_ram_model.sv
// Purpose: 1024x1 static ram model
// Assumes: pins active low
// Notes: invalid output inverts
`timescale 1ns/1ns
module srk_ram_model
   import srk_pkg::*;
#(
   parameter int ACC_NS = ACCESS_MAX_NS
) (
   input  logic [ADDR_W-1:0] ram_addr,
   input  logic              ram_din,
   input  logic              ram_select_n,
   input  logic              ram_write_n,
   output logic              ram_dout
);
   logic    mem [DEPTH];
   realtime t_chg;
   initial ram_dout = 1'b0;
   // store as the strobe ends while selected
   always @(posedge ram_write_n) begin
      if (!ram_select_n) mem[ram_addr] = ram_din;
   end
   // any address, select or strobe change spoils the output
   always @(ram_addr, ram_select_n, ram_write_n) begin
      t_chg = $realtime;
      ram_dout = ~ram_dout;
   end
   // settled read data while selected
   always #2 begin
      if (!ram_select_n && ram_write_n && $realtime - t_chg >= ACC_NS) ram_dout = mem[ram_addr];
   end
endmodule

// ===== sim/srk_ctrl_sva.sv
// Purpose: pin timing checks
// Assumes: srk_ctrl ports
// Notes: counters time long lows
`timescale 1ns/1ns
module srk_ctrl_sva
   import srk_pkg::*;
(
   input logic              mclk,
   input logic              rstn,
   input logic              req_valid,
   input logic              req_ready,
   input logic              req_write,
   input logic              rsp_valid,
   input logic [ADDR_W-1:0] ram_addr,
   input logic              ram_din,
   input logic              ram_select_n,
   input logic              ram_write_n
);
   logic [7:0] lo, sl;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // low cycles of strobe and select
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lo <= 8'h00;
         sl <= 8'h00;
      end else begin
         lo <= ram_write_n ? 8'h00 : lo + 8'h01;
         sl <= ram_select_n ? 8'h00 : sl + 8'h01;
      end
   end
   a_take_selects: assert property (req_valid && req_ready |=> !ram_select_n) else $error("sel");
   a_strobe_in_select: assert property (!ram_write_n |-> !ram_select_n) else $error("stb");
   a_pins_held: assert property (!ram_select_n && $past(!ram_select_n) |-> $stable({ram_addr, ram_din})) else $error("pin");
   a_addr_setup: assert property ($fell(ram_write_n) |-> $past(!ram_select_n, 2)) else $error("setup");
   a_strobe_width: assert property ($rose(ram_write_n) |-> lo >= WRITE_STROBE_WIDTH_CYC) else $error("wid");
   a_cycle_length: assert property ($rose(ram_select_n) |-> sl >= READ_CYCLE_MIN_CYC) else $error("cyc");
   a_write_answer: assert property ($rose(ram_write_n) |-> ##13 rsp_valid) else $error("ans");
   a_read_answer: assert property (req_valid && req_ready && !req_write |-> ##51 rsp_valid) else $error("rans");
   a_read_no_strobe: assert property (req_valid && req_ready && !req_write |=> ram_write_n [*8]) else $error("rd");
   c_read: cover property (req_valid && req_ready && !req_write);
   c_write: cover property ($rose(ram_write_n));
   c_answer: cover property (rsp_valid);
endmodule
bind srk_ctrl srk_ctrl_sva srk_ctrl_sva_i (.*);

// ===== sim/tb_srk_ctrl.sv
// Purpose: random write and read-back
// Assumes: ram model on the pins
// Notes: drives on falling edge
`timescale 1ns/1ns
module tb_srk_ctrl
   import srk_pkg::*;
;
   logic              mclk, rstn, req_valid, req_ready, req_write, req_wdata, rsp_valid, rsp_rdata;
   logic              ram_din, ram_select_n, ram_write_n, ram_dout;
   logic [ADDR_W-1:0] req_addr, ram_addr;
   logic              shadow [DEPTH];
   logic [31:0]       r;
   int                failures, samples_checked, seed, n, k;
   srk_ctrl srk_ctrl_i (.*);
   srk_ram_model srk_ram_model_i (.*);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic give_verdict();
      if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one request; waits for ready, then the answer
   task automatic op(input logic wr, input logic [ADDR_W-1:0] a, input logic d);
      {req_write, req_addr, req_wdata, req_valid} = {wr, a, d, 1'b1};
      for (k = 0; k < 9 && req_ready !== 1'b1; k++) @(negedge mclk);
      if (k == 9) begin
         failures++;
         $display("[ERR] req_ready expected 1 seen %b", req_ready);
         give_verdict();
      end
      @(negedge mclk);
      req_valid = 1'b0;
      for (k = 0; k < 99 && rsp_valid !== 1'b1; k++) @(negedge mclk);
      samples_checked++;
      if (k == 99 || (!wr && rsp_rdata !== shadow[a])) begin
         failures++;
         $display("[ERR] rsp_rdata expected %b seen %b", shadow[a], rsp_rdata);
         if (k == 99) give_verdict();
      end
      if (wr) shadow[a] = d;
   endtask
   initial begin
      seed = 32'h0771;
      {rstn, req_valid, req_write, req_wdata, req_addr} = '0;
      repeat (3) @(negedge mclk);
      rstn = 1'b1;
      // fill both ends, then mix reads and writes there
      for (n = 0; n < 16; n++) begin
         r = $random(seed);
         op(1'b1, {{7{n[3]}}, n[2:0]}, r[0]);
      end
      for (n = 0; n < 40; n++) begin
         r = $random(seed);
         op(r[4] & r[5], {{7{r[3]}}, r[2:0]}, r[0]);
      end
      give_verdict();
   end
endmodule
